// *** src/audio_route_pkg.sv ***
// Register map, field layouts and rate constants of the audio route and core run block
package audio_route_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [15:0] OFS_CORE_FRAME_RATE   = 16'h40eb;
   localparam logic [15:0] OFS_ADC_OUTPUT_ROUTE  = 16'h40f3;
   localparam logic [15:0] OFS_SERIAL_PIN_SELECT = 16'h40f4;
   localparam logic [15:0] OFS_CORE_RUN_CONTROL  = 16'h40f6;
   localparam logic [15:0] OFS_PORT_SAMPLE_RATE  = 16'h40f8;

   // ----------------------------------------------------------------
   // Field widths and reset values
   // ----------------------------------------------------------------
   localparam int          ROUTE_W          = 4;
   localparam int          PIN_W            = 4;
   localparam int          FRATE_W          = 4;
   localparam int          PRATE_W          = 3;
   localparam int          SAMPLE_W         = 24;
   localparam int          SLOT_N           = 8;
   localparam int          PERIOD_W         = 5;
   localparam logic [3:0]  ROUTE_RESET      = 4'h0;
   localparam logic [3:0]  PIN_RESET        = 4'h0;
   localparam logic [0:0]  RUN_RESET        = 1'h0;
   localparam logic [3:0]  FRATE_RESET      = 4'h0;
   localparam logic [2:0]  PRATE_RESET      = 3'h0;

   // Pin bit positions
   localparam int          PIN_FRAME_CLK    = 3;
   localparam int          PIN_BIT_CLK      = 2;
   localparam int          PIN_DATA_OUT     = 1;
   localparam int          PIN_DATA_IN      = 0;

   // Route code: zero sends converters through the core
   localparam logic [3:0]  ROUTE_VIA_CORE   = 4'h0;
   localparam int          ROUTE_SWAP_BIT   = 3;

   // Core frame rate codes with a special meaning
   localparam logic [3:0]  FRATE_PORT_IN    = 4'h7;
   localparam logic [3:0]  FRATE_PORT_OUT   = 4'h8;
   localparam logic [3:0]  FRATE_NONE_MIN   = 4'ha;

   // Periods in ticks of the 4 x base rate strobe
   localparam logic [4:0]  PER_X4           = 5'h01;
   localparam logic [4:0]  PER_X2           = 5'h02;
   localparam logic [4:0]  PER_X1           = 5'h04;
   localparam logic [4:0]  PER_D1_5         = 5'h06;
   localparam logic [4:0]  PER_D2           = 5'h08;
   localparam logic [4:0]  PER_D3           = 5'h0c;
   localparam logic [4:0]  PER_D4           = 5'h10;
   localparam logic [4:0]  PER_D6           = 5'h18;

endpackage

// *** src/frame_pacer.sv ***
// Frame start pulse generator dividing the 4 x base rate strobe
`timescale 1ns/1ps
module frame_pacer (
   input  wire logic                                   clk_sys_i,
   input  wire logic                                   reset_n_i,
   input  wire logic                                   tick_i,
   input  wire logic                                   enable_i,
   input  wire logic [audio_route_pkg::PERIOD_W-1:0]   period_i,
   output logic                                        pulse_o
);

   logic [audio_route_pkg::PERIOD_W-1:0] count_q;
   logic [audio_route_pkg::PERIOD_W-1:0] count_d;
   logic                                 wrap;

   // Wrap on the last tick of a period; disabled pacer restarts from zero
   assign wrap    = enable_i && tick_i && (count_q >= period_i - 5'h01);
   assign count_d = !enable_i ? '0 :
                    wrap      ? '0 :
                    tick_i    ? count_q + 5'h01 : count_q;

   // Counter and pulse, pulse lasts one clock
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         count_q <= '0;
         pulse_o <= 1'b0;
      end else begin
         count_q <= count_d;
         pulse_o <= wrap;
      end
   end

endmodule

// *** src/audio_route_core_run_ctrl.sv ***
// Audio output routing, serial pin function, core run and rate control registers
//
// Function
// - Output routing field bits 3..0, upper bits reserved, resets to zero.
// - Routing code zero passes converter samples through the processing core.
// - Codes 1,3,5,7 place converter left/right straight into channel 0..3 slots.
// - Codes 9,b,d,f place converter left/right swapped into channel 0..3 slots.
// - A set pin configuration bit makes that pin a core general line.
// - Clear bits keep audio roles: 3 frame clock, 2 bit clock, 1 out, 0 in.
// - Run bit 0 resets clear; clear means standby, set means run.
// - When running, the core steps only on a new frame start.
// - Port rate field bits 2..0, upper bits reserved, resets to zero.
// - Port rate codes divide base rate by 1,6,4,3,2,1.5,0.5; 111 reserved.
// - Core frame rate sets frame start pace; codes 1010 up issue none.
`timescale 1ns/1ps
module audio_route_core_run_ctrl (
   input  wire logic                                   clk_sys_i,
   input  wire logic                                   reset_n_i,
   // Control port register access
   input  wire logic [15:0]                            reg_addr_i,
   input  wire logic                                   reg_wr_i,
   input  wire logic [7:0]                             reg_wdata_i,
   input  wire logic                                   reg_rd_i,
   output logic [7:0]                                  reg_rdata_o,
   output logic                                        reg_rvalid_o,
   // Audio timing and samples
   input  wire logic                                   rate_tick_i,
   input  wire logic [audio_route_pkg::SAMPLE_W-1:0]   adc_left_i,
   input  wire logic [audio_route_pkg::SAMPLE_W-1:0]   adc_right_i,
   input  wire logic [audio_route_pkg::SAMPLE_W-1:0]   core_slot_i [audio_route_pkg::SLOT_N],
   output logic [audio_route_pkg::SAMPLE_W-1:0]        serial_slot_o [audio_route_pkg::SLOT_N],
   output logic                                        adc_to_core_o,
   // Serial port pins and core general lines
   input  wire logic [audio_route_pkg::PIN_W-1:0]      pin_in_i,
   input  wire logic [audio_route_pkg::PIN_W-1:0]      audio_pin_out_i,
   input  wire logic [audio_route_pkg::PIN_W-1:0]      audio_pin_oe_i,
   input  wire logic [audio_route_pkg::PIN_W-1:0]      core_line_out_i,
   input  wire logic [audio_route_pkg::PIN_W-1:0]      core_line_oe_i,
   output logic [audio_route_pkg::PIN_W-1:0]           pin_out_o,
   output logic [audio_route_pkg::PIN_W-1:0]           pin_oe_o,
   output logic [audio_route_pkg::PIN_W-1:0]           core_line_in_o,
   output logic [audio_route_pkg::PIN_W-1:0]           pin_is_general_o,
   // Core control
   output logic                                        core_standby_o,
   output logic                                        core_step_o,
   output logic                                        port_frame_o
);

   // ----------------------------------------------------------------
   // Registers and decode
   // ----------------------------------------------------------------
   logic [audio_route_pkg::ROUTE_W-1:0] route_q;
   logic [audio_route_pkg::PIN_W-1:0]   pin_sel_q;
   logic                                run_q;
   logic [audio_route_pkg::FRATE_W-1:0] frate_q;
   logic [audio_route_pkg::PRATE_W-1:0] prate_q;
   logic [7:0]                          rdata_d;
   logic                                hit_route;
   logic                                hit_pin;
   logic                                hit_run;
   logic                                hit_frate;
   logic                                hit_prate;

   // Address decode shared by write and read paths
   assign hit_route = (reg_addr_i == audio_route_pkg::OFS_ADC_OUTPUT_ROUTE);
   assign hit_pin   = (reg_addr_i == audio_route_pkg::OFS_SERIAL_PIN_SELECT);
   assign hit_run   = (reg_addr_i == audio_route_pkg::OFS_CORE_RUN_CONTROL);
   assign hit_frate = (reg_addr_i == audio_route_pkg::OFS_CORE_FRAME_RATE);
   assign hit_prate = (reg_addr_i == audio_route_pkg::OFS_PORT_SAMPLE_RATE);

   // Reserved bits read zero; unmapped addresses read zero
   assign rdata_d = hit_route ? {4'h0, route_q}   :
                    hit_pin   ? {4'h0, pin_sel_q} :
                    hit_run   ? {7'h00, run_q}    :
                    hit_frate ? {4'h0, frate_q}   :
                    hit_prate ? {5'h00, prate_q}  : 8'h00;

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         route_q   <= audio_route_pkg::ROUTE_RESET;
         pin_sel_q <= audio_route_pkg::PIN_RESET;
         run_q     <= audio_route_pkg::RUN_RESET;
         frate_q   <= audio_route_pkg::FRATE_RESET;
         prate_q   <= audio_route_pkg::PRATE_RESET;
      end else if (reg_wr_i) begin
         if (hit_route) route_q   <= reg_wdata_i[3:0];
         if (hit_pin)   pin_sel_q <= reg_wdata_i[3:0];
         if (hit_run)   run_q     <= reg_wdata_i[0];
         if (hit_frate) frate_q   <= reg_wdata_i[3:0];
         if (hit_prate) prate_q   <= reg_wdata_i[2:0];
      end
   end

   // Read answer one clock after the strobe
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         reg_rdata_o  <= 8'h00;
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rdata_o  <= reg_rd_i ? rdata_d : reg_rdata_o;
         reg_rvalid_o <= reg_rd_i;
      end
   end

   // ----------------------------------------------------------------
   // Rate decode
   // ----------------------------------------------------------------
   // Port period in quarter base-rate ticks; reserved 111 falls to 1x
   function automatic logic [4:0] port_period(input logic [2:0] code);
      case (code)
         3'h1:    port_period = audio_route_pkg::PER_D6;
         3'h2:    port_period = audio_route_pkg::PER_D4;
         3'h3:    port_period = audio_route_pkg::PER_D3;
         3'h4:    port_period = audio_route_pkg::PER_D2;
         3'h5:    port_period = audio_route_pkg::PER_D1_5;
         3'h6:    port_period = audio_route_pkg::PER_X2;
         default: port_period = audio_route_pkg::PER_X1;
      endcase
   endfunction

   // Core period; serial in and out rate codes follow the port rate
   function automatic logic [4:0] core_period(input logic [3:0] code,
                                               input logic [4:0] port_per);
      case (code)
         4'h0:    core_period = audio_route_pkg::PER_X2;
         4'h1:    core_period = audio_route_pkg::PER_X1;
         4'h2:    core_period = audio_route_pkg::PER_D1_5;
         4'h3:    core_period = audio_route_pkg::PER_D2;
         4'h4:    core_period = audio_route_pkg::PER_D3;
         4'h5:    core_period = audio_route_pkg::PER_D4;
         4'h6:    core_period = audio_route_pkg::PER_D6;
         4'h9:    core_period = audio_route_pkg::PER_X4;
         default: core_period = port_per;
      endcase
   endfunction

   logic [4:0] port_per;
   logic [4:0] core_per;
   logic       core_frames_on;
   logic       core_frame;
   logic       core_frame_q;

   assign port_per       = port_period(prate_q);
   assign core_per       = core_period(frate_q, port_per);
   // codes from 1010 upward stop all core frame starts; port frame starts continue
   assign core_frames_on = (frate_q < audio_route_pkg::FRATE_NONE_MIN);

   frame_pacer u_port_pacer (
      .clk_sys_i (clk_sys_i),
      .reset_n_i (reset_n_i),
      .tick_i    (rate_tick_i),
      .enable_i  (1'b1),
      .period_i  (port_per),
      .pulse_o   (port_frame_o)
   );

   frame_pacer u_core_pacer (
      .clk_sys_i (clk_sys_i),
      .reset_n_i (reset_n_i),
      .tick_i    (rate_tick_i),
      .enable_i  (core_frames_on),
      .period_i  (core_per),
      .pulse_o   (core_frame)
   );

   // standby when clear, step only on a frame start while running
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         core_standby_o <= 1'b1;
         core_step_o    <= 1'b0;
         core_frame_q   <= 1'b0;
      end else begin
         core_standby_o <= !run_q;
         core_frame_q   <= core_frame;
         core_step_o    <= run_q && core_frame_q;
      end
   end

   // ----------------------------------------------------------------
   // Output slot routing
   // ----------------------------------------------------------------
   logic [1:0] route_chan;
   logic       route_direct;
   logic       route_swap;

   // Odd codes are direct; reserved even codes fall back to the core path
   assign route_chan   = route_q[2:1];
   assign route_direct = route_q[0];
   assign route_swap   = route_q[audio_route_pkg::ROUTE_SWAP_BIT];

   // converters feed the core when no direct route is chosen
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         adc_to_core_o <= 1'b1;
      end else begin
         adc_to_core_o <= !route_direct;
      end
   end

   // Slot 2c is left, 2c+1 right of channel c
   for (genvar s = 0; s < audio_route_pkg::SLOT_N; s++) begin : g_slot
      logic       sel;
      logic       is_right;
      logic [23:0] slot_d;
      assign sel      = route_direct && (route_chan == 2'(s / 2));
      assign is_right = (s % 2) == 1;
      // direct placement, swapped for the upper code half
      assign slot_d   = !sel                   ? core_slot_i[s] :
                        (is_right ^ route_swap) ? adc_right_i    : adc_left_i;
      always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
         if (!reset_n_i) begin
            serial_slot_o[s] <= '0;
         end else begin
            serial_slot_o[s] <= slot_d;
         end
      end
   end

   // ----------------------------------------------------------------
   // Pin function
   // ----------------------------------------------------------------
   logic [3:0] pin_out_d;
   logic [3:0] pin_oe_d;
   logic [3:0] line_in_d;

   // set bit hands the pin to the core, clear keeps its audio role
   assign pin_out_d = (pin_sel_q & core_line_out_i) | (~pin_sel_q & audio_pin_out_i);
   assign pin_oe_d  = (pin_sel_q & core_line_oe_i)  | (~pin_sel_q & audio_pin_oe_i);
   assign line_in_d = pin_sel_q & pin_in_i;

   // Registered so every pin output leaves a flip-flop
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pin_out_o        <= 4'h0;
         pin_oe_o         <= 4'h0;
         core_line_in_o   <= 4'h0;
         pin_is_general_o <= 4'h0;
      end else begin
         pin_out_o        <= pin_out_d;
         pin_oe_o         <= pin_oe_d;
         core_line_in_o   <= line_in_d;
         pin_is_general_o <= pin_sel_q;
      end
   end

endmodule

// *** tb/audio_route_checker.sv ***
// Port checks for the audio route and core run block
`timescale 1ns/1ps
module audio_route_checker (
   input  wire logic                                 clk_sys_i,
   input  wire logic                                 reset_n_i,
   input  wire logic [15:0]                          reg_addr_i,
   input  wire logic                                 reg_rd_i,
   input  wire logic [7:0]                           reg_rdata_o,
   input  wire logic                                 reg_rvalid_o,
   input  wire logic [audio_route_pkg::SAMPLE_W-1:0] core_slot_i [audio_route_pkg::SLOT_N],
   input  wire logic [audio_route_pkg::SAMPLE_W-1:0] serial_slot_o [audio_route_pkg::SLOT_N],
   input  wire logic                                 adc_to_core_o,
   input  wire logic [3:0]                           audio_pin_oe_i,
   input  wire logic [3:0]                           pin_oe_o,
   input  wire logic [3:0]                           core_line_in_o,
   input  wire logic [3:0]                           pin_is_general_o,
   input  wire logic                                 core_standby_o,
   input  wire logic                                 core_step_o,
   input  wire logic                                 port_frame_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);
   a_read_answer_timing: assert property (reg_rvalid_o == $past(reg_rd_i))
      else $error("read answer not one cycle after strobe");
   a_route_upper_zero: assert property (reg_rd_i && reg_addr_i == 16'h40f3 |=> reg_rdata_o[7:4] == 4'h0)
      else $error("routing reserved bits read nonzero");
   a_rate_upper_zero: assert property (reg_rd_i && reg_addr_i == 16'h40f8 |=> reg_rdata_o[7:3] == 5'h00)
      else $error("port rate reserved bits read nonzero");
   a_run_upper_zero: assert property (reg_rd_i && reg_addr_i == 16'h40f6 |=> reg_rdata_o[7:1] == 7'h00)
      else $error("run reserved bits read nonzero");
   a_step_needs_run: assert property (core_step_o |-> !core_standby_o)
      else $error("core step while in standby");
   a_line_needs_select: assert property ((core_line_in_o & ~pin_is_general_o) == 4'h0)
      else $error("core line fed from an audio pin");
   // audio drive passes through one cycle later
   a_audio_pin_drive: assert property ($past(reset_n_i) |-> ((pin_oe_o ^ $past(audio_pin_oe_i)) & ~pin_is_general_o) == 4'h0)
      else $error("audio pin enable not passed through");
   a_core_path_slots: assert property (adc_to_core_o && $past(reset_n_i) |-> serial_slot_o[0] == $past(core_slot_i[0]) && serial_slot_o[7] == $past(core_slot_i[7]))
      else $error("core path slot not from core");
   a_frame_single_pulse: assert property (port_frame_o |=> !port_frame_o)
      else $error("port frame pulse longer than one cycle");
endmodule

// *** tb/audio_host_model.sv ***
// Host software model driving the control port registers
`timescale 1ns/1ps
module audio_host_model #(
   parameter int STOP_WAIT_CYC = 300000 // 3 ms at 100 MHz
) (
   input  wire logic        clk_sys_i,
   output logic [15:0]      reg_addr_o,
   output logic             reg_wr_o,
   output logic [7:0]       reg_wdata_o,
   output logic             reg_rd_o,
   input  wire logic [7:0]  reg_rdata_i
);
   initial begin
      reg_addr_o = 16'hffff;
      reg_wr_o = 1'b0;
      reg_wdata_o = 8'hff;
      reg_rd_o = 1'b0;
   end
   // One-cycle write; released bus shows inverted values so stale data cannot match
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      reg_addr_o <= a;
      reg_wdata_o <= d;
      reg_wr_o <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr_o <= 1'b0;
      reg_addr_o <= ~a;
      reg_wdata_o <= ~d;
   endtask
   // One-cycle read; data taken at the edge where the answer is sampled
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk_sys_i);
      reg_addr_o <= a;
      reg_rd_o <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd_o <= 1'b0;
      reg_addr_o <= ~a;
      @(posedge clk_sys_i);
      d = reg_rdata_i;
   endtask
   task automatic stop_core();
      wr(16'h40eb, 8'h7f);
      repeat (STOP_WAIT_CYC) @(posedge clk_sys_i);
      wr(16'h40f6, 8'h00);
   endtask
   // valid pace before run; caller keeps rates matched
   task automatic start_core(input logic [7:0] code);
      wr(16'h40eb, code);
      wr(16'h40f6, 8'h01);
   endtask
endmodule

// *** tb/audio_route_core_run_ctrl_test.sv ***
// Self-checking bench for the audio route and core run block
`timescale 1ns/1ps
module audio_route_core_run_ctrl_test;
   localparam int SW = audio_route_pkg::SAMPLE_W;
   logic          clk_sys_i, reset_n_i, tick_en, reg_wr, reg_rd, reg_rvalid;
   logic          rate_tick_i = 1'b0;
   logic          adc_to_core, standby, step, frame;
   logic [1:0]    tick_cnt = 2'h0;
   logic [15:0]   reg_addr;
   logic [7:0]    wdata, rdata, got;
   logic [SW-1:0] adc_l, adc_r;
   logic [SW-1:0] core_slot [audio_route_pkg::SLOT_N];
   logic [SW-1:0] ser_slot [audio_route_pkg::SLOT_N];
   logic [3:0]    pin_in, aud_out, aud_oe, core_out, core_oe, pin_out, pin_oe, line_in, pin_gen;
   int            n_errors = 0, checks_done = 0, n_port = 0, n_step = 0;
   int            per [7] = '{4, 24, 16, 12, 8, 6, 2};
   // Core periods in ticks; codes 7 and 8 follow the port rate, held at /2
   int            cper [10] = '{2, 4, 6, 8, 12, 16, 24, 8, 8, 1};
   audio_route_core_run_ctrl dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
      .reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_wdata_i(wdata), .reg_rd_i(reg_rd),
      .reg_rdata_o(rdata), .reg_rvalid_o(reg_rvalid), .rate_tick_i(rate_tick_i),
      .adc_left_i(adc_l), .adc_right_i(adc_r), .core_slot_i(core_slot),
      .serial_slot_o(ser_slot), .adc_to_core_o(adc_to_core), .pin_in_i(pin_in),
      .audio_pin_out_i(aud_out), .audio_pin_oe_i(aud_oe), .core_line_out_i(core_out),
      .core_line_oe_i(core_oe), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
      .core_line_in_o(line_in), .pin_is_general_o(pin_gen), .core_standby_o(standby),
      .core_step_o(step), .port_frame_o(frame));
   audio_host_model #(.STOP_WAIT_CYC(200)) u_host (.clk_sys_i(clk_sys_i),
      .reg_addr_o(reg_addr), .reg_wr_o(reg_wr), .reg_wdata_o(wdata), .reg_rd_o(reg_rd),
      .reg_rdata_i(rdata));
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   // Rate strobe every fourth cycle; pulses counted mid-cycle to avoid edge races
   always @(posedge clk_sys_i) begin
      tick_cnt <= tick_cnt + 2'h1;
      rate_tick_i <= tick_en && tick_cnt == 2'h0;
   end
   always @(negedge clk_sys_i) begin
      n_port += int'(frame === 1'b1);
      n_step += int'(step === 1'b1);
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
      u_host.rd(a, got);
      check(got, exp);
   endtask
   // Settle one window after a rate change, then count over n ticks
   task automatic window(input int n);
      repeat (n * 4) @(posedge clk_sys_i);
      n_port = 0;
      n_step = 0;
      repeat (n * 4) @(posedge clk_sys_i);
   endtask
   function automatic logic [SW-1:0] exp_slot(input int c, input int s);
      if (c % 2 == 0 || s / 2 != (c / 2) % 4) return core_slot[s];
      return ((s % 2 == 1) ^ (c >= 8)) ? adc_r : adc_l;
   endfunction
   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Watchdog sized well above the roughly 8000 cycles of the tests
   initial begin
      repeat (30000) @(posedge clk_sys_i);
      n_errors++;
      print_verdict();
   end
   initial begin
      {reset_n_i, tick_en, pin_in, aud_out, aud_oe, core_out, core_oe} = '0;
      {adc_l, adc_r} = '0;
      for (int i = 0; i < 8; i++) core_slot[i] = 24'h100000 + 24'(i);
      repeat (10) @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      rd_chk(16'h40f3, 8'h00);
      rd_chk(16'h40f4, 8'h00);
      rd_chk(16'h40f6, 8'h00);
      rd_chk(16'h40f8, 8'h00);
      rd_chk(16'h40eb, 8'h00);
      check(standby, 1'b1);
      u_host.wr(16'h40f3, 8'hf3);
      rd_chk(16'h40f3, 8'h03);
      u_host.wr(16'h40f8, 8'hfd);
      rd_chk(16'h40f8, 8'h05);
      u_host.wr(16'h40f5, 8'h5a);
      rd_chk(16'h40f5, 8'h00);
      // only zero and odd routing codes written
      for (int c = 0; c < 16; c++) begin
         if (c != 0 && c % 2 == 0) continue;
         @(posedge clk_sys_i);
         adc_l <= 24'h0a0000 + 24'(c);
         adc_r <= 24'hf00000 + 24'(c);
         u_host.wr(16'h40f3, 8'(c));
         repeat (2) @(negedge clk_sys_i);
         check(adc_to_core, c == 0);
         for (int s = 0; s < 8; s++) check(ser_slot[s], exp_slot(c, s));
      end
      @(posedge clk_sys_i);
      {pin_in, aud_oe, core_oe, aud_out, core_out} <= 20'h6c395;
      u_host.wr(16'h40f4, 8'h0a);
      repeat (2) @(negedge clk_sys_i);
      check(line_in, 4'ha & pin_in);
      check(pin_gen, 4'ha);
      check(pin_oe, (aud_oe & 4'h5) | (core_oe & 4'ha));
      check(pin_out, (aud_out & 4'h5) | (core_out & 4'ha));
      tick_en <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         u_host.wr(16'h40f8, 8'(i));
         window(48);
         check(n_port, 48 / per[i]);
         check(n_step, 0);
      end
      // pacing codes 0 to 9, port at /2 so codes 7 and 8 show it
      u_host.wr(16'h40f8, 8'h04);
      for (int i = 0; i < 10; i++) begin
         u_host.start_core(8'(i));
         window(48);
         check(n_step, 48 / cper[i]);
         check(n_port, 48 / per[4]);
      end
      u_host.wr(16'h40f8, 8'h00);
      u_host.start_core(8'h01);
      window(48);
      check(n_step, 12);
      check(standby, 1'b0);
      u_host.stop_core();
      window(48);
      check(n_step, 0);
      check(standby, 1'b1);
      rd_chk(16'h40eb, 8'h0f);
      u_host.start_core(8'h09);
      window(48);
      check(n_step, 48);
      print_verdict();
   end
endmodule
bind audio_route_core_run_ctrl audio_route_checker u_chk (.clk_sys_i(clk_sys_i),
   .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .core_slot_i(core_slot_i),
   .serial_slot_o(serial_slot_o), .adc_to_core_o(adc_to_core_o),
   .audio_pin_oe_i(audio_pin_oe_i), .pin_oe_o(pin_oe_o), .core_line_in_o(core_line_in_o),
   .pin_is_general_o(pin_is_general_o), .core_standby_o(core_standby_o),
   .core_step_o(core_step_o), .port_frame_o(port_frame_o));
